// ===== core/urs_sequencer.sv
// Run-state sequencer: power-up, diagnostics, ready, run, test, hold,
// stop, print and report, with five ultrasonic operating modes.
// Assumes keypad strobes are one-cycle pulses on clk_sys, and that the
// probe reading and done flags come from outside and need syncing.
//
// Notes on behaviour
// - Continuous mode runs until stop or hold, or until a nonzero duration elapses
// - Timed mode ends when duration elapses
// - Pulse mode alternates on and off intervals
// - Temp mode without limits ends at upper setpoint
// - Temp mode with time suspends, resumes 3 below
// - Pulse/pause slows with own ratio past lower
// - Pulse/pause off at upper until 3 below
// - Pulse/pause refreshes shown temperatures each second
// - Enabled duration stops cycle, upper setpoint only in timed, pulse and untimed temp; OFF limits ignored
// - Power-up starts fan, goes to diagnostics
// - Diagnostics steps, lights all, ready on pass
// - Parameters and new cycles only when ready
// - Start enters run, start lamp stays lit
// - Test drives output, back to ready 2 s
// - Print after cycle or test, then ready
// - Remote report after cycle or test, then ready
// - Hold freezes timers, second hold resumes
// - Stop during cycle or test aborts it
//
// The register addresses and register access over APB were chosen for this implementation.
module urs_sequencer #(
  parameter int TENTH_CYCLES = urs_pkg::TENTH_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic key_start_stop,
  input wire logic key_hold,
  input wire logic key_test,
  input wire logic key_print,
  input wire logic [11:0] temp_probe,
  input wire logic diag_ok,
  input wire logic print_done,
  input wire logic send_done,
  output logic fan_on,
  output logic diag_leds,
  output logic [2:0] diag_step,
  output logic sonic_on,
  output logic start_lamp,
  output logic print_go,
  output logic send_go
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    urs_pkg::urs_state_t st;
    logic held_test;
    logic have_res;
    urs_pkg::urs_mode_t mode;
    logic rem_en;
    logic [15:0] t_lim;
    logic [15:0] p_on;
    logic [15:0] p_off;
    logic [11:0] t_max;
    logic [11:0] t_pp;
    logic [23:0] div;
    logic [15:0] run;
    logic [15:0] ph;
    logic ph_off;
    logic cool;
    logic slow;
    logic [3:0] sec;
    logic [2:0] dstep;
    logic [11:0] tp1;
    logic [11:0] tp2;
    logic [11:0] tp3;
    logic [11:0] temp;
    logic [11:0] show_t;
    logic [11:0] show_m;
    logic [2:0] f1;
    logic [2:0] f2;
    logic [2:0] f3;
    logic [2:0] fv;
    logic fan;
    logic leds;
    logic sonic;
    logic lamp;
    logic prn_go;
    logic snd_go;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } urs_regs_t;

  localparam logic [23:0] TENTH_LAST = 24'(TENTH_CYCLES - 1);

  urs_regs_t r_reg;
  urs_regs_t r_next;

  logic wacc;
  logic tick;
  logic [5:0] cmd;
  logic c_start;
  logic c_stop;
  logic c_hold;
  logic act;

  // ----------------------------------------------------------------
  // Command gathering
  // ----------------------------------------------------------------
  // A write lands at the edge where pready is seen high
  assign wacc = psel & penable & pwrite & r_reg.pready;
  assign tick = (r_reg.div == TENTH_LAST);
  assign act = (r_reg.st == urs_pkg::S_RUN) |
               (r_reg.st == urs_pkg::S_TEST) |
               (r_reg.st == urs_pkg::S_HOLD);
  // Keypad strobes merged with remote command bits
  assign cmd = ((wacc && paddr == urs_pkg::A_CMD) ? pwdata[5:0] : 6'h00)
             | {1'b0, key_print, key_test, key_hold, 2'b00};
  assign c_start = cmd[urs_pkg::C_START] |
                   (key_start_stop & ~act);
  assign c_stop = cmd[urs_pkg::C_STOP] | (key_start_stop & act);
  assign c_hold = cmd[urs_pkg::C_HOLD];

  // Outputs come straight from the state record
  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign fan_on = r_reg.fan;
  assign diag_leds = r_reg.leds;
  assign diag_step = r_reg.dstep;
  assign sonic_on = r_reg.sonic;
  assign start_lamp = r_reg.lamp;
  assign print_go = r_reg.prn_go;
  assign send_go = r_reg.snd_go;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Whole block: syncs, bus, timers and the run sequencer
  always_comb begin
    logic [31:0] rd;
    logic hit;
    logic hot;
    logic cooled;
    logic pulsed;
    logic done;
    logic [15:0] on_len;
    logic [15:0] off_len;
    logic [15:0] ph_inc;
    rd = 32'h0000_0000;
    hit = 1'b1;
    hot = (r_reg.t_max != 12'h000) && (r_reg.temp >= r_reg.t_max);
    cooled = ({1'b0, r_reg.temp} + {1'b0, urs_pkg::HYST_DEG})
             <= {1'b0, r_reg.t_max};
    pulsed = (r_reg.mode == urs_pkg::M_PULSE) ||
             ((r_reg.mode == urs_pkg::M_PP) &&
              (r_reg.slow || r_reg.p_on != 16'h0000));
    on_len = r_reg.p_on;
    off_len = r_reg.p_off;
    ph_inc = r_reg.ph + 16'h0001;
    done = 1'b0;
    r_next = r_reg;
    r_next.prn_go = 1'b0;
    r_next.snd_go = 1'b0;

    // Three-stage syncs; a value counts once stages two and three agree
    r_next.tp1 = temp_probe;
    r_next.tp2 = r_reg.tp1;
    r_next.tp3 = r_reg.tp2;
    if (r_reg.tp2 == r_reg.tp3) begin
      r_next.temp = r_reg.tp3;
    end
    r_next.f1 = {diag_ok, print_done, send_done};
    r_next.f2 = r_reg.f1;
    r_next.f3 = r_reg.f2;
    if (r_reg.f2 == r_reg.f3) begin
      r_next.fv = r_reg.f3;
    end

    // Read decode and APB answer one cycle into the access phase
    if (paddr == urs_pkg::A_CTRL) begin
      rd = {28'h0, r_reg.rem_en, r_reg.mode};
    end else if (paddr == urs_pkg::A_TIME) begin
      rd = {16'h0, r_reg.t_lim};
    end else if (paddr == urs_pkg::A_PON) begin
      rd = {16'h0, r_reg.p_on};
    end else if (paddr == urs_pkg::A_POFF) begin
      rd = {16'h0, r_reg.p_off};
    end else if (paddr == urs_pkg::A_TMAX) begin
      rd = {20'h0, r_reg.t_max};
    end else if (paddr == urs_pkg::A_TPP) begin
      rd = {20'h0, r_reg.t_pp};
    end else if (paddr == urs_pkg::A_CMD) begin
      rd = 32'h0000_0000;
    end else if (paddr == urs_pkg::A_STAT) begin
      rd = {r_reg.run, 3'h0, r_reg.dstep, r_reg.sonic, r_reg.lamp,
            r_reg.have_res, r_reg.cool, r_reg.slow, r_reg.ph_off,
            r_reg.st};
    end else if (paddr == urs_pkg::A_SHOW) begin
      rd = {4'h0, r_reg.show_m, 4'h0, r_reg.show_t};
    end else begin
      hit = 1'b0;
    end
    r_next.pready = psel & penable & ~r_reg.pready;
    r_next.pslverr = 1'b0;
    if (r_next.pready) begin
      r_next.pslverr = ~hit;
      r_next.prdata = pwrite ? 32'h0000_0000 : rd;
    end

    if (wacc && r_reg.st == urs_pkg::S_READY) begin
      if (paddr == urs_pkg::A_CTRL) begin
        r_next.mode = urs_pkg::urs_mode_t'(pwdata[2:0]);
        r_next.rem_en = pwdata[urs_pkg::CTRL_REM];
      end else if (paddr == urs_pkg::A_TIME) begin
        r_next.t_lim = pwdata[15:0];
      end else if (paddr == urs_pkg::A_PON) begin
        r_next.p_on = pwdata[15:0];
      end else if (paddr == urs_pkg::A_POFF) begin
        r_next.p_off = pwdata[15:0];
      end else if (paddr == urs_pkg::A_TMAX) begin
        r_next.t_max = pwdata[11:0];
      end else if (paddr == urs_pkg::A_TPP) begin
        r_next.t_pp = pwdata[11:0];
      end
    end

    // tenth-second divider stands still in hold
    if (r_reg.st != urs_pkg::S_HOLD) begin
      r_next.div = tick ? 24'h000000 : r_reg.div + 24'h000001;
    end

    if (r_reg.mode == urs_pkg::M_PP && r_reg.slow) begin
      on_len = (r_reg.p_on != 16'h0000) ? r_reg.p_on
                                        : urs_pkg::PP_DEF_ON;
      off_len = {on_len[14:0], 1'b0};
    end

    case (r_reg.st)
      urs_pkg::S_PWRUP: begin
        r_next.fan = 1'b1;
        r_next.st = urs_pkg::S_DIAG;
      end
      urs_pkg::S_DIAG: begin
        // step through checks, all lamps lit
        r_next.leds = 1'b1;
        if (r_reg.dstep != urs_pkg::DIAG_LAST) begin
          if (tick) begin
            r_next.dstep = r_reg.dstep + 3'h1;
          end
        end else if (r_reg.fv[urs_pkg::F_DIAG]) begin
          r_next.leds = 1'b0;
          r_next.st = urs_pkg::S_READY;
        end
      end
      urs_pkg::S_READY: begin
        // start and test only taken here
        r_next.run = 16'h0000;
        r_next.ph = 16'h0000;
        r_next.ph_off = 1'b0;
        r_next.cool = 1'b0;
        r_next.slow = 1'b0;
        r_next.sec = 4'h0;
        if (c_start) begin
          r_next.st = urs_pkg::S_RUN;
          r_next.have_res = 1'b0;
        end else if (cmd[urs_pkg::C_TEST]) begin
          r_next.st = urs_pkg::S_TEST;
          r_next.have_res = 1'b0;
        end else if (cmd[urs_pkg::C_PRINT] && r_reg.have_res) begin
          r_next.st = urs_pkg::S_PRINT;
          r_next.prn_go = 1'b1;
        end else if (cmd[urs_pkg::C_SEND] && r_reg.have_res &&
                     r_reg.rem_en) begin
          r_next.st = urs_pkg::S_REPORT;
          r_next.snd_go = 1'b1;
        end
      end
      urs_pkg::S_RUN: begin
        if (tick && !r_reg.cool) begin
          r_next.run = r_reg.run + 16'h0001;
        end
        if (pulsed && tick) begin
          if (ph_inc >= (r_reg.ph_off ? off_len : on_len)) begin
            r_next.ph = 16'h0000;
            r_next.ph_off = ~r_reg.ph_off;
          end else begin
            r_next.ph = ph_inc;
          end
        end
        case (r_reg.mode)
          urs_pkg::M_TIMED, urs_pkg::M_PULSE: begin
            done = hot;
          end
          urs_pkg::M_TEMP: begin
            if (r_reg.t_lim == 16'h0000) begin
              done = hot;
            end else if (hot) begin
              r_next.cool = 1'b1;
            end else if (r_reg.cool && cooled) begin
              r_next.cool = 1'b0;
            end
          end
          urs_pkg::M_PP: begin
            // lower setpoint switches to own ratio
            if (r_reg.t_pp != 12'h000 && r_reg.temp >= r_reg.t_pp) begin
              r_next.slow = 1'b1;
            end
            // off at upper until three below
            if (hot) begin
              r_next.cool = 1'b1;
            end else if (r_reg.cool && cooled) begin
              r_next.cool = 1'b0;
            end
            if (tick) begin
              r_next.sec = r_reg.sec + 4'h1;
              if (r_reg.sec == urs_pkg::SEC_TENTHS - 4'h1) begin
                r_next.sec = 4'h0;
                r_next.show_t = r_reg.temp;
                r_next.show_m = r_reg.t_max;
              end
            end
          end
          default: begin
            done = 1'b0;
          end
        endcase
        if (r_reg.t_lim != 16'h0000 && r_reg.run >= r_reg.t_lim) begin
          done = 1'b1;
        end
        if (c_stop || done) begin
          r_next.st = urs_pkg::S_STOP;
        end else if (c_hold) begin
          r_next.st = urs_pkg::S_HOLD;
          r_next.held_test = 1'b0;
        end
      end
      urs_pkg::S_TEST: begin
        if (tick) begin
          r_next.run = r_reg.run + 16'h0001;
        end
        if (c_stop) begin
          r_next.st = urs_pkg::S_STOP;
        end else if (c_hold) begin
          r_next.st = urs_pkg::S_HOLD;
          r_next.held_test = 1'b1;
        end else if (r_reg.run >= urs_pkg::TEST_TENTHS) begin
          r_next.st = urs_pkg::S_READY;
          r_next.have_res = 1'b1;
        end
      end
      urs_pkg::S_HOLD: begin
        // second hold resumes the same phase
        if (c_stop) begin
          r_next.st = urs_pkg::S_STOP;
        end else if (c_hold) begin
          r_next.st = r_reg.held_test ? urs_pkg::S_TEST
                                      : urs_pkg::S_RUN;
        end
      end
      urs_pkg::S_PRINT: begin
        if (r_reg.fv[urs_pkg::F_PRN]) begin
          r_next.st = urs_pkg::S_READY;
        end
      end
      urs_pkg::S_REPORT: begin
        if (r_reg.fv[urs_pkg::F_SND]) begin
          r_next.st = urs_pkg::S_READY;
        end
      end
      default: begin
        r_next.st = urs_pkg::S_READY;
        r_next.have_res = 1'b1;
      end
    endcase

    // output per mode, lamp lit through the cycle
    r_next.sonic = ((r_next.st == urs_pkg::S_RUN) &&
                    !(pulsed && r_next.ph_off) && !r_next.cool) ||
                   (r_next.st == urs_pkg::S_TEST);
    r_next.lamp = (r_next.st == urs_pkg::S_RUN) ||
                  ((r_next.st == urs_pkg::S_HOLD) && !r_next.held_test);
  end

  // Single register stage for the whole record
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Helper for temperature checks
  logic hot_w;
  assign hot_w = (r_reg.t_max != 12'h000) && (r_reg.temp >= r_reg.t_max);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_run_in(urs_pkg::urs_mode_t m);
    r_reg.st == urs_pkg::S_RUN && r_reg.mode == m && !c_stop && !c_hold;
  endsequence

  sequence s_abort;
    act && c_stop;
  endsequence

  a_cont_keeps_on: assert property (
    s_run_in(urs_pkg::M_CONT) |=> r_reg.st == urs_pkg::S_RUN && r_reg.sonic)
    else $error("continuous run dropped output");
  a_timed_ends: assert property (
    s_run_in(urs_pkg::M_TIMED) ##0 (r_reg.t_lim != 16'h0000 &&
    r_reg.run >= r_reg.t_lim) |=> r_reg.st == urs_pkg::S_STOP)
    else $error("timed run did not end");
  a_pulse_off_quiet: assert property (
    r_reg.st == urs_pkg::S_RUN && r_reg.mode == urs_pkg::M_PULSE &&
    r_reg.ph_off |-> !r_reg.sonic)
    else $error("output on during off interval");
  a_temp_reach_end: assert property (
    s_run_in(urs_pkg::M_TEMP) ##0 (r_reg.t_lim == 16'h0000 && hot_w)
    |=> r_reg.st == urs_pkg::S_STOP)
    else $error("temperature run did not end");
  a_cool_freezes: assert property (
    r_reg.st == urs_pkg::S_RUN && r_reg.cool |->
    !r_reg.sonic ##1 r_reg.run == $past(r_reg.run))
    else $error("timer or output ran while cooling");
  a_pp_slowdown: assert property (
    s_run_in(urs_pkg::M_PP) ##0 (r_reg.t_pp != 12'h000 &&
    r_reg.temp >= r_reg.t_pp) |=> r_reg.slow)
    else $error("ratio not applied past lower setpoint");
  a_pp_upper_off: assert property (
    s_run_in(urs_pkg::M_PP) ##0 hot_w |=> r_reg.cool && !r_reg.sonic)
    else $error("output not off at upper setpoint");
  a_diag_lamps: assert property (
    r_reg.st == urs_pkg::S_DIAG ##1 r_reg.st == urs_pkg::S_DIAG
    |-> r_reg.leds && r_reg.fan)
    else $error("diagnostics without lamps or fan");
  a_powerup_diag: assert property (
    r_reg.st == urs_pkg::S_PWRUP |=> r_reg.st == urs_pkg::S_DIAG)
    else $error("power-up did not enter diagnostics");
  a_run_lamp: assert property (
    r_reg.st == urs_pkg::S_RUN |-> r_reg.lamp)
    else $error("start lamp dark during run");
  a_test_length: assert property (
    r_reg.st == urs_pkg::S_TEST |-> r_reg.run <= urs_pkg::TEST_TENTHS)
    else $error("test ran too long");
  a_hold_frozen: assert property (
    r_reg.st == urs_pkg::S_HOLD |-> !r_reg.sonic ##1 $stable(r_reg.run) &&
    $stable(r_reg.ph))
    else $error("timers moved in hold");
  a_stop_aborts: assert property (
    s_abort |=> r_reg.st == urs_pkg::S_STOP ##1 r_reg.st == urs_pkg::S_READY)
    else $error("stop did not abort");
  a_start_from_ready: assert property (
    $rose(r_reg.st == urs_pkg::S_RUN) |->
    $past(r_reg.st) == urs_pkg::S_READY || $past(r_reg.st) == urs_pkg::S_HOLD)
    else $error("run entered from wrong state");

endmodule

// ===== core/urs_pkg.sv
// Shared constants and types for the ultrasonic run sequencer.
// Assumes a single 125 MHz system clock and an APB register bus.
package urs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 125000000;
  localparam int TENTH_MS = 100;
  localparam int TEST_MS = 2000;
  localparam int SEC_MS = 1000;
  localparam int TENTH_CYC = CLK_HZ / 1000 * TENTH_MS;
  localparam logic [15:0] TEST_TENTHS = 16'(TEST_MS / TENTH_MS);
  localparam logic [3:0] SEC_TENTHS = 4'(SEC_MS / TENTH_MS);
  localparam logic [11:0] HYST_DEG = 12'h003;
  localparam logic [15:0] PP_DEF_ON = 16'h000a;
  localparam logic [2:0] DIAG_LAST = 3'h7;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TIME = 8'h04;
  localparam logic [7:0] A_PON = 8'h08;
  localparam logic [7:0] A_POFF = 8'h0c;
  localparam logic [7:0] A_TMAX = 8'h10;
  localparam logic [7:0] A_TPP = 8'h14;
  localparam logic [7:0] A_CMD = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1c;
  localparam logic [7:0] A_SHOW = 8'h20;
  localparam int CTRL_REM = 3;
  localparam int C_START = 0;
  localparam int C_STOP = 1;
  localparam int C_HOLD = 2;
  localparam int C_TEST = 3;
  localparam int C_PRINT = 4;
  localparam int C_SEND = 5;
  localparam int F_DIAG = 2;
  localparam int F_PRN = 1;
  localparam int F_SND = 0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_PWRUP, S_DIAG, S_READY, S_RUN, S_TEST,
    S_PRINT, S_REPORT, S_HOLD, S_STOP
  } urs_state_t;

  typedef enum logic [2:0] {
    M_CONT, M_TIMED, M_PULSE, M_TEMP, M_PP
  } urs_mode_t;

endpackage

// ===== test/urs_operator_model.sv
// Operator model: front keypad strobes, temperature probe, diagnostics
// pass level, and the printer and report link finishing their jobs.
// Assumes clk_sys is the sequencer clock; the bench calls its tasks.
module urs_operator_model (
  input wire logic clk_sys,
  input wire logic print_go,
  input wire logic send_go,
  output logic key_start_stop,
  output logic key_hold,
  output logic key_test,
  output logic key_print,
  output logic [11:0] temp_probe,
  output logic diag_ok,
  output logic print_done,
  output logic send_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int dly = 2;
  int pc = 0;
  int sc = 0;
  int up = 0;
  logic [3:0] keys = 4'h0;

  // ----------------------------------------------------------------
  // Keypad
  // ----------------------------------------------------------------
  // Keys in order start/stop, hold, test, print
  assign key_start_stop = keys[0];
  assign key_hold = keys[1];
  assign key_test = keys[2];
  assign key_print = keys[3];

  // One-cycle key strobe, launched right after an edge
  task automatic press(input int k);
    @(posedge clk_sys);
    keys <= 4'h1 << k;
    @(posedge clk_sys);
    keys <= 4'h0;
  endtask

  // ----------------------------------------------------------------
  // Probe and completion levels
  // ----------------------------------------------------------------
  // probe always attached
  initial temp_probe = 12'h014;
  task automatic set_temp(input logic [11:0] t);
    @(posedge clk_sys);
    temp_probe <= t;
  endtask

  // Done levels come dly cycles after the job starts, for 8 cycles
  always @(posedge clk_sys) begin
    up <= up + 1;
    pc <= print_go ? dly + 8 : (pc > 0 ? pc - 1 : 0);
    sc <= send_go ? dly + 8 : (sc > 0 ? sc - 1 : 0);
  end
  assign diag_ok = (up > 20);
  assign print_done = (pc > 0) && (pc <= 8);
  assign send_done = (sc > 0) && (sc <= 8);
endmodule

// ===== test/ultrasonic_run_sequencer_tb.sv
// Self-checking bench for the run sequencer: APB master, operator
// model on the keypad side, random timed-mode durations.
// Assumes a short tenth divider so runs stay brief.
module ultrasonic_run_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 8;
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic fan_on, diag_leds, sonic_on, start_lamp, print_go, send_go;
  logic key_start_stop, key_hold, key_test, key_print;
  logic diag_ok, print_done, send_done;
  logic [11:0] temp_probe;
  logic [2:0] diag_step;
  int n_mismatch, num_checks, n, t;

  urs_sequencer #(.TENTH_CYCLES(TC)) urs_sequencer_i (.clk_sys, .rst_b,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .key_start_stop, .key_hold, .key_test, .key_print, .temp_probe,
    .diag_ok, .print_done, .send_done, .fan_on, .diag_leds, .diag_step,
    .sonic_on, .start_lamp, .print_go, .send_go);
  urs_operator_model urs_operator_model_i (.clk_sys, .print_go, .send_go,
    .key_start_stop, .key_hold, .key_test, .key_print, .temp_probe,
    .diag_ok, .print_done, .send_done);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected shown word: temperature low, upper setpoint high
  function automatic logic [31:0] show_exp(input logic [11:0] c, m);
    return {4'h0, m, 4'h0, c};
  endfunction
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // APB transfer; request held until the edge that samples pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    // Sample pready as it stands at each rising edge
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      chk(1'b0, "apb timeout");
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input int b);
    apb(1'b1, urs_pkg::A_CMD, 32'h1 << b);
  endtask
  task automatic st_is(input logic [3:0] s, input string m);
    apb(1'b0, urs_pkg::A_STAT, 32'h0);
    chk(rd[3:0] === s, m);
  endtask
  task automatic wst(input logic [3:0] s, input int lim);
    int k;
    k = 0;
    do begin
      apb(1'b0, urs_pkg::A_STAT, 32'h0);
      k++;
    end while (rd[3:0] !== s && k < lim);
    chk(rd[3:0] === s, "state wait");
  endtask
  task automatic setp(input logic [31:0] m, tm, mx, pp, on, off);
    apb(1'b1, urs_pkg::A_CTRL, m);
    apb(1'b1, urs_pkg::A_TIME, tm);
    apb(1'b1, urs_pkg::A_TMAX, mx);
    apb(1'b1, urs_pkg::A_TPP, pp);
    apb(1'b1, urs_pkg::A_PON, on);
    apb(1'b1, urs_pkg::A_POFF, off);
  endtask
  task automatic wait_n(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    wait_n(90000);
    chk(1'b0, "run timeout");
    complete_run();
  end
  initial begin
    rnd = 32'hafe6;
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    wait_n(2);
    chk(fan_on === 1'b1, "fan off");
    chk(diag_leds === 1'b1, "lamps off");
    wst(urs_pkg::S_READY, 60);
    rnd = lfsr(rnd);
    apb(1'b1, 8'h24, rnd);
    chk(err === 1'b1, "unmapped ok");
    setp(0, 0, 0, 0, 0, 0);
    urs_operator_model_i.press(0);
    wait_n(2);
    chk(sonic_on && start_lamp, "no run");
    apb(1'b1, urs_pkg::A_TIME, 32'h9);
    cmd(urs_pkg::C_START);
    cmd(urs_pkg::C_TEST);
    wait_n(200);
    st_is(urs_pkg::S_RUN, "cont ended");
    urs_operator_model_i.press(1);
    wait_n(2);
    st_is(urs_pkg::S_HOLD, "no hold");
    chk(!sonic_on && start_lamp, "hold out");
    t = rd[31:16];
    wait_n(40);
    apb(1'b0, urs_pkg::A_STAT, 32'h0);
    chk(rd[31:16] === t[15:0], "timer ran");
    cmd(urs_pkg::C_HOLD);
    wait_n(2);
    chk(sonic_on === 1'b1, "no resume");
    cmd(urs_pkg::C_STOP);
    wst(urs_pkg::S_READY, 5);
    chk(!sonic_on && !start_lamp, "stop out");
    apb(1'b0, urs_pkg::A_TIME, 32'h0);
    chk(rd === 32'h0, "late write");
    urs_operator_model_i.dly = 40;
    urs_operator_model_i.press(3);
    st_is(urs_pkg::S_PRINT, "no print");
    wst(urs_pkg::S_READY, 30);
    apb(1'b1, urs_pkg::A_CTRL, 32'h8);
    cmd(urs_pkg::C_SEND);
    st_is(urs_pkg::S_REPORT, "no send");
    wst(urs_pkg::S_READY, 30);
    urs_operator_model_i.dly = 1;
    urs_operator_model_i.press(2);
    wait_n(2);
    chk(sonic_on === 1'b1, "test out");
    wait_n(15 * TC);
    st_is(urs_pkg::S_TEST, "test short");
    wst(urs_pkg::S_READY, 30);
    rnd = lfsr(rnd);
    t = 3 + int'(rnd[1:0]);
    setp(1, t, 0, 0, 0, 0);
    cmd(urs_pkg::C_START);
    wait_n(2 * TC);
    st_is(urs_pkg::S_RUN, "timed short");
    wst(urs_pkg::S_READY, 3 * t);
    setp(2, 40, 0, 0, 2, 2);
    cmd(urs_pkg::C_START);
    n = 0;
    repeat (16 * TC) begin
      wait_n(1);
      n += int'(sonic_on === 1'b1);
    end
    chk(n >= 7 * TC && n <= 9 * TC, "pulse duty");
    wst(urs_pkg::S_READY, 60);
    setp(3, 0, 50, 0, 0, 0);
    cmd(urs_pkg::C_START);
    urs_operator_model_i.set_temp(12'd60);
    wst(urs_pkg::S_READY, 8);
    setp(3, 4, 50, 0, 0, 0);
    cmd(urs_pkg::C_START);
    wait_n(6 * TC);
    st_is(urs_pkg::S_RUN, "no freeze");
    chk(sonic_on === 1'b0, "hot out");
    urs_operator_model_i.set_temp(12'd47);
    wait_n(8);
    chk(sonic_on === 1'b1, "no cool");
    wst(urs_pkg::S_READY, 20);
    setp(4, 0, 50, 40, 0, 0);
    urs_operator_model_i.set_temp(12'd45);
    cmd(urs_pkg::C_START);
    n = 0;
    repeat (30 * TC) begin
      wait_n(1);
      n += int'(sonic_on === 1'b0);
    end
    chk(n > 0, "no slowing");
    apb(1'b0, urs_pkg::A_SHOW, 32'h0);
    chk(rd === show_exp(12'd45, 12'd50), "show");
    urs_operator_model_i.set_temp(12'd60);
    wait_n(8);
    chk(sonic_on === 1'b0, "pp hot out");
    urs_operator_model_i.press(0);
    wst(urs_pkg::S_READY, 5);
    complete_run();
  end
endmodule
